// File: common/sajc_consts.vh
/*
 * constants for the slot address reporter and scan chain manager:
 * field positions, timing counts and chain routing codes.
 * assumes a 20 MHz system clock; included by bare name.
 */
`ifndef SAJC_CONSTS_VH
`define SAJC_CONSTS_VH

// slot identifier layout
`define SAJC_ID_W 5
`define SAJC_GA_W 4
`define SAJC_ID_SITE_BIT 4
`define SAJC_SITE_A 1'h0
`define SAJC_SITE_B 1'h1

// request line settle time and filtered cycle count at 50 ns per cycle
`define SAJC_CLK_PERIOD_NS 50
`define SAJC_REQ_SETTLE_NS 200
`define SAJC_REQ_SETTLE_CYC ((`SAJC_REQ_SETTLE_NS + `SAJC_CLK_PERIOD_NS - 1) / `SAJC_CLK_PERIOD_NS)

// bit counter width and reset value
`define SAJC_CNT_W 3
`define SAJC_CNT_RST 3'h0

// scan chain position codes
`define SAJC_POS_W 2
`define SAJC_POS_SITE_B 2'h0
`define SAJC_POS_SITE_A 2'h1
`define SAJC_POS_SELF 2'h2

`endif

// File: hw/sajc_sync.v
/*
 * two flip-flop synchroniser for a bundle of levels from outside the clock domain.
 * assumes inputs are static levels or slow compared with clk.
 */
`timescale 1ns/1ps
`default_nettype none

module sajc_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // levels
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage feeds only the second stage
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

`default_nettype wire

// File: hw/sajc_top.v
/*
 * carrier housekeeping: slot identifier reporter toward two mezzanine sites
 * and the boundary scan chain router between the programmer header and the sites.
 * assumes the mezzanine owns the management clock and request wires and
 * that site present lines are high when a module is seated.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sajc_consts.vh"

// Summary of operation
// [RULE1] the slot identifier is five bits: one site bit plus the four backplane address bits.
// [RULE2] the identifier goes out one bit per request clock edge, only while the module requests it.
// [RULE3] an empty site is bypassed so scan data still flows from header input to header output.
// [RULE4] with both sites populated, site B comes first in the chain and site A follows.
// [RULE5] the reporter itself sits in the chain as one more device with a one-bit bypass stage.
// [RULE6] the programmer drives mode select and test clock to every chain device in common; the own stage takes only a synchronised test clock and no mode select.
// [RULE7] programmer data enters the first device and the last device output returns to the header.
// [RULE8] the mezzanine module owns and drives the management clock and data request lines.
// [RULE9] a module without scan ties its data input to its output so the chain passes through.
// [RULE10] the site bit is zero for site A and one for site B and sits above the address bits.
module sajc_top (
    // clock and reset
    input wire clk,
    input wire resetn,
    // backplane geographical address and site presence
    input wire [3:0] backplane_geo_address,
    input wire site_a_present,
    input wire site_b_present,
    // management wires from site A (clock, request) and data back
    input wire site_a_mgmt_clk,
    input wire site_a_mgmt_req,
    output wire site_a_mgmt_data_o,
    output wire site_a_mgmt_data_oe,
    // management wires from site B
    input wire site_b_mgmt_clk,
    input wire site_b_mgmt_req,
    output wire site_b_mgmt_data_o,
    output wire site_b_mgmt_data_oe,
    // programmer header scan pins
    input wire hdr_tck,
    input wire hdr_tms,
    input wire hdr_tdi,
    output wire hdr_tdo,
    // scan pins toward the sites, returns from the sites
    output wire site_b_tdi,
    input wire site_b_tdo,
    output wire site_a_tdi,
    input wire site_a_tdo,
    output wire site_tck,
    output wire site_tms
);

    // the address, presence, management and header tck/tdi inputs pass two flip-flops before internal use
    wire [11:0] s_in;
    wire [3:0] ga_s;
    wire pres_a_s, pres_b_s, clk_a_s, req_a_s, clk_b_s, req_b_s;
    wire tck_s, tdi_s;

    sajc_sync #(
        .W(12)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({backplane_geo_address, site_a_present, site_b_present, site_a_mgmt_clk,
                   site_a_mgmt_req, site_b_mgmt_clk, site_b_mgmt_req, hdr_tck, hdr_tdi}),
        .sync_out(s_in)
    );

    assign ga_s = s_in[11:8];
    assign pres_a_s = s_in[7];
    assign pres_b_s = s_in[6];
    assign clk_a_s = s_in[5];
    assign req_a_s = s_in[4];
    assign clk_b_s = s_in[3];
    assign req_b_s = s_in[2];
    assign tck_s = s_in[1];
    assign tdi_s = s_in[0];

    // identifier for a given site: site bit above the address nibble
    function [`SAJC_ID_W-1:0] slot_id;
        input site;
        input [`SAJC_GA_W-1:0] ga;
        begin
            slot_id = {site, ga}; // [RULE1] [RULE10]
        end
    endfunction

    // request state per site
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg st_a_q, st_b_q;
    reg [`SAJC_ID_W-1:0] sh_a_q, sh_b_q;
    reg [`SAJC_CNT_W-1:0] cnt_a_q, cnt_b_q;
    reg clk_a_d1_q, clk_b_d1_q;
    wire fall_a = clk_a_d1_q & ~clk_a_s;
    wire fall_b = clk_b_d1_q & ~clk_b_s;

    // site A reporter: load on request, shift msb first on each of the first four falling management clocks
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_a_q <= ST_IDLE;
            sh_a_q <= {`SAJC_ID_W{1'b0}};
            cnt_a_q <= `SAJC_CNT_RST;
            clk_a_d1_q <= 1'b0;
        end else begin
            clk_a_d1_q <= clk_a_s;
            case (st_a_q)
                ST_IDLE: begin
                    if (req_a_s) begin // [RULE2] [RULE8]
                        st_a_q <= ST_SEND;
                        sh_a_q <= slot_id(`SAJC_SITE_A, ga_s);
                        cnt_a_q <= `SAJC_CNT_RST;
                    end
                end
                ST_SEND: begin
                    if (!req_a_s) begin
                        st_a_q <= ST_IDLE;
                    end else if (fall_a && cnt_a_q != (`SAJC_ID_W - 1)) begin
                        sh_a_q <= {sh_a_q[`SAJC_ID_W-2:0], 1'b0}; // [RULE2]
                        cnt_a_q <= cnt_a_q + 3'h1;
                    end
                end
                default: st_a_q <= ST_IDLE;
            endcase
        end
    end

    // site B reporter, same sequence with the site bit set
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_b_q <= ST_IDLE;
            sh_b_q <= {`SAJC_ID_W{1'b0}};
            cnt_b_q <= `SAJC_CNT_RST;
            clk_b_d1_q <= 1'b0;
        end else begin
            clk_b_d1_q <= clk_b_s;
            case (st_b_q)
                ST_IDLE: begin
                    if (req_b_s) begin // [RULE2] [RULE8]
                        st_b_q <= ST_SEND;
                        sh_b_q <= slot_id(`SAJC_SITE_B, ga_s);
                        cnt_b_q <= `SAJC_CNT_RST;
                    end
                end
                ST_SEND: begin
                    if (!req_b_s) begin
                        st_b_q <= ST_IDLE;
                    end else if (fall_b && cnt_b_q != (`SAJC_ID_W - 1)) begin
                        sh_b_q <= {sh_b_q[`SAJC_ID_W-2:0], 1'b0}; // [RULE2]
                        cnt_b_q <= cnt_b_q + 3'h1;
                    end
                end
                default: st_b_q <= ST_IDLE;
            endcase
        end
    end

    // data drives only while a request is being served; otherwise released
    assign site_a_mgmt_data_o = sh_a_q[`SAJC_ID_W-1];
    assign site_a_mgmt_data_oe = (st_a_q == ST_SEND);
    assign site_b_mgmt_data_o = sh_b_q[`SAJC_ID_W-1];
    assign site_b_mgmt_data_oe = (st_b_q == ST_SEND);

    // own bypass stage: captures header data on a rising test clock
    // limitation: only a bypass register is modelled, enough to be found and skipped
    reg tck_d1_q, own_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tck_d1_q <= 1'b0;
            own_q <= 1'b0;
        end else begin
            tck_d1_q <= tck_s;
            if (tck_s && !tck_d1_q) begin
                own_q <= tdi_s; // [RULE5] [RULE7]
            end
        end
    end

    // common mode select and clock fanned out unbuffered to both sites
    assign site_tck = hdr_tck; // [RULE6]
    assign site_tms = hdr_tms; // [RULE6]

    // chain order: own stage, site B, site A, header; empty sites bypassed
    // routing is combinational on the return path so it adds no test clock latency
    assign site_b_tdi = own_q; // [RULE4] [RULE5]
    wire after_b = pres_b_s ? site_b_tdo : own_q; // [RULE3] [RULE9]
    assign site_a_tdi = after_b; // [RULE4]
    assign hdr_tdo = pres_a_s ? site_a_tdo : after_b; // [RULE3] [RULE7]

endmodule

`default_nettype wire

// File: sim/sajc_asserts.sv
/* checker for sajc_top: chain routing and id link timing.
   assumes the bench holds tdi steady across each scan clock rise. */
`timescale 1ns/1ps
`default_nettype none
module sajc_asserts (
    // clock, reset, presence
    input wire logic clk, resetn, site_a_present, site_b_present,
    // id link
    input wire logic site_a_mgmt_req, site_a_mgmt_data_o, site_a_mgmt_data_oe,
    input wire logic site_b_mgmt_req, site_b_mgmt_data_o, site_b_mgmt_data_oe,
    // scan chain
    input wire logic hdr_tck, hdr_tdi, hdr_tdo, site_b_tdi, site_b_tdo, site_a_tdi, site_a_tdo
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // presence is filtered, so routing is judged only once it has settled
    a_b_bypass: assert property ((!site_b_present)[*5] |-> site_a_tdi == site_b_tdi)
        else $error("empty site b not bypassed");
    a_b_first: assert property (site_b_present[*5] |-> site_a_tdi == site_b_tdo)
        else $error("site b not ahead of site a");
    a_a_last: assert property (site_a_present[*5] |-> hdr_tdo == site_a_tdo)
        else $error("header return not from site a");
    a_own_stage: assert property ($rose(hdr_tck) && $stable(hdr_tdi) |-> ##5 site_b_tdi == $past(hdr_tdi, 5))
        else $error("own stage missed data");
    a_oe_no_req: assert property ((!site_a_mgmt_req)[*5] |-> !site_a_mgmt_data_oe)
        else $error("id driven without request");
    a_b_oe_idle: assert property ((!site_b_mgmt_req)[*5] |-> !site_b_mgmt_data_oe)
        else $error("site b id driven without request");
    a_site_bit_a: assert property ($rose(site_a_mgmt_req) |-> ##5 site_a_mgmt_data_oe && !site_a_mgmt_data_o)
        else $error("site a first bit wrong");
    a_site_bit_b: assert property ($rose(site_b_mgmt_req) |-> ##5 site_b_mgmt_data_oe && site_b_mgmt_data_o)
        else $error("site b first bit wrong");
endmodule
bind sajc_top sajc_asserts u_chk (.clk, .resetn, .site_a_present, .site_b_present, .site_a_mgmt_req,
    .site_a_mgmt_data_o, .site_a_mgmt_data_oe, .site_b_mgmt_req, .site_b_mgmt_data_o, .site_b_mgmt_data_oe,
    .hdr_tck, .hdr_tdi, .hdr_tdo, .site_b_tdi, .site_b_tdo, .site_a_tdi, .site_a_tdo);
`default_nettype wire

// File: sim/sajc_mezz_model.sv
/* mezzanine model: reads the id over the mgmt wires, one scan stage or a pass-through.
   assumes the bench clock paces its requests. */
`timescale 1ns/1ps
`default_nettype none
module sajc_mezz_model (
    // pacing and options
    input wire logic clk, present, scan_en,
    // management wires
    output logic mgmt_clk, mgmt_req,
    input wire logic data_o, data_oe,
    // scan wires
    input wire logic tck, tdi,
    output logic tdo
);
    logic stage_q = 1'b0;
    // one bypass bit when scan is used
    always @(posedge tck) stage_q <= tdi;
    // an empty socket floats, shown as the inverse of its input
    assign tdo = !present ? ~tdi : scan_en ? stage_q : tdi;
    initial begin
        mgmt_clk = 1'b1;
        mgmt_req = 1'b0;
    end
    // clock rests high between reads; an undriven data line reads high
    task automatic read_id(output logic [4:0] v);
        v = 5'h0;
        @(negedge clk) mgmt_req = 1'b1;
        repeat (6) @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            v = {v[3:0], data_oe ? data_o : 1'b1};
            mgmt_clk = 1'b0;
            repeat (5) @(negedge clk);
            mgmt_clk = 1'b1;
            repeat (3) @(negedge clk);
        end
        mgmt_req = 1'b0;
        repeat (6) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// File: sim/tb_slot_address_jtag_chain.sv
/* bench for sajc_top: two mezzanine models, header scan traffic at 400 ns.
   assumes the checker is bound to the top. */
`timescale 1ns/1ps
`default_nettype none
module tb_slot_address_jtag_chain;
    logic clk = 1'b0, resetn = 1'b0, pa = 1'b0, pb = 1'b0, tck = 1'b0, tms = 1'b0, tdi = 1'b0;
    logic ea = 1'b0, eb = 1'b0;
    logic [3:0] ga = 4'h0;
    logic [4:0] got;
    logic q[$];
    wire amc, amr, ad, aoe, bmc, bmr, bd, boe, btdi, btdo, atdi, atdo, stck, stms, tdo;
    int fails = 0, num_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    sajc_top DUT (.clk(clk), .resetn(resetn), .backplane_geo_address(ga), .site_a_present(pa),
        .site_b_present(pb), .site_a_mgmt_clk(amc), .site_a_mgmt_req(amr), .site_a_mgmt_data_o(ad),
        .site_a_mgmt_data_oe(aoe), .site_b_mgmt_clk(bmc), .site_b_mgmt_req(bmr), .site_b_mgmt_data_o(bd),
        .site_b_mgmt_data_oe(boe), .hdr_tck(tck), .hdr_tms(tms), .hdr_tdi(tdi), .hdr_tdo(tdo),
        .site_b_tdi(btdi), .site_b_tdo(btdo), .site_a_tdi(atdi), .site_a_tdo(atdo), .site_tck(stck),
        .site_tms(stms));
    // each round gives one site a scan stage and the other a straight pass-through,
    // so a wrongly bypassed seated site shows up on either side of the chain
    sajc_mezz_model ma (.clk(clk), .present(pa), .scan_en(ea), .mgmt_clk(amc), .mgmt_req(amr),
        .data_o(ad), .data_oe(aoe), .tck(stck), .tdi(atdi), .tdo(atdo));
    sajc_mezz_model mb (.clk(clk), .present(pb), .scan_en(eb), .mgmt_clk(bmc), .mgmt_req(bmr),
        .data_o(bd), .data_oe(boe), .tck(stck), .tdi(btdi), .tdo(btdo));
    task automatic check(input logic [4:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // the run needs about 2000 cycles; this cuts off a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'hb316_267d));
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        for (int k = 0; k < 8; k++) begin
            {pb, pa} = k[1:0];
            // lower rounds put the scan stage on site b, upper rounds on site a
            eb = ~k[2];
            ea = k[2];
            ga = 4'($urandom);
            repeat (8) @(negedge clk);
            ma.read_id(got);
            check(got, {1'b0, ga});
            mb.read_id(got);
            check(got, {1'b1, ga});
            q = {};
            // own stage lags the scan clock, so each seated scan site adds exactly one bit
            for (int n = 0; n < 16; n++) begin
                tdi = 1'($urandom);
                tms = 1'($urandom);
                q.push_back(tdi);
                repeat (4) @(negedge clk);
                tck = 1'b1;
                repeat (4) @(negedge clk);
                if (n > 1) check(5'(tdo), 5'(q[n - (pa & ea) - (pb & eb)]));
                check(5'({stck, stms}), 5'({tck, tms}));
                tck = 1'b0;
            end
        end
        stop_test();
    end
endmodule
`default_nettype wire
